// [inc/liu_serial_consts.svh]
// constants for the line interface unit serial host port
`ifndef LIU_SERIAL_CONSTS_SVH
`define LIU_SERIAL_CONSTS_SVH

// register offsets on the processor port
`define CMD_OFF        9'h022
`define DATA_OFF       9'h023
`define STAT_OFF       9'h024
`define SETUP_OFF      9'h025

// field positions
`define DIR_BIT        0
`define DONE_BIT       0
`define SEL_BIT        7
`define RATE_BIT       6
`define IRQEN_BIT      0

// reset values
`define BYTE_RST       8'h00

// frame geometry: 16 serial clocks per transaction
`define FRAME_BITS     5'h10
`define BYTE_BITS      5'h08
`define LAST_BIT       5'h0F

// serial clock rates, derived from the link clock
`define LINK_CLK_KHZ   16384
`define SLOW_KHZ       1024
`define FAST_KHZ       8192
`define HALF_SLOW      (`LINK_CLK_KHZ / (2 * `SLOW_KHZ))
`define HALF_FAST      (`LINK_CLK_KHZ / (2 * `FAST_KHZ))

`endif

// [inc/liu_serial_pkg.sv]
// types shared by the serial host port design files
package liu_serial_pkg;

  // control byte as it travels: address above, direction in bit 0
  typedef struct packed {
    logic [6:0] remote_reg_addr;  // register inside the far unit
    logic       op_direction_bit; // 0 write, 1 read
  } cmd_byte_t;

  // everything the link side needs for one transaction
  typedef struct packed {
    logic       select_choice_bit; // 0 select a, 1 select b
    logic       shift_rate_bit;    // 0 slow, 1 fast
    cmd_byte_t  cmd;               // control byte
    logic [7:0] data;              // data byte for writes
  } link_req_t;

  // link side sequencer
  typedef enum logic [2:0] {
    L_IDLE,
    L_LEAD,
    L_LOW,
    L_HIGH,
    L_TAIL
  } link_state_t;

endpackage

// [rtl/toggle_sync.sv]
// toggle to pulse crossing into the receiving clock domain
`timescale 1ns/1ps
`default_nettype none

module toggle_sync (
  input  wire logic clk_in,   // receiving clock
  input  wire logic nrst_in,  // receiving reset, active low
  input  wire logic tgl_in,   // toggle from the other domain
  output logic      pulse_out // one cycle per toggle
);

  logic meta_ff; // first stage, read only by the second
  logic sync_ff; // second stage
  logic last_ff; // previous synced value

  ////////////////////////////////////////////////////////////////////////
  // two stage synchroniser plus history
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      last_ff <= 1'b0;
    end else begin
      meta_ff <= tgl_in;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end

  // any change of the synced level is one event
  assign pulse_out = sync_ff ^ last_ff;

endmodule

`default_nettype wire

// [rtl/shift_tick_gen.sv]
// half period tick generator for the serial clock
`timescale 1ns/1ps
`default_nettype none

module shift_tick_gen (
  input  wire logic lclk_in,  // link clock
  input  wire logic nrst_in,  // link reset, active low
  input  wire logic run_in,   // count while high
  input  wire logic fast_in,  // 1 fast rate, 0 slow rate
  output logic      tick_out  // one cycle per half period
);

  import liu_serial_pkg::*;
  `include "liu_serial_consts.svh"

  logic [3:0] cnt_ff; // cycles within the half period

  // last count of a half period for the chosen rate
  function automatic logic [3:0] half_limit(input logic fast);
    half_limit = fast ? 4'((`HALF_FAST) - 1) : 4'((`HALF_SLOW) - 1);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // counter restarts whenever the frame is not running
  always_ff @(posedge lclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_ff   <= 4'h0;
      tick_out <= 1'b0;
    end else if (!run_in) begin
      cnt_ff   <= 4'h0;
      tick_out <= 1'b0;
    end else if (cnt_ff == half_limit(fast_in)) begin
      cnt_ff   <= 4'h0;
      tick_out <= 1'b1;
    end else begin
      cnt_ff   <= cnt_ff + 4'h1;
      tick_out <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// [rtl/liu_serial_host_port.sv]
// serial register port toward an external line interface unit
//
// Functional notes
// [RULE_01] command byte write launches one transaction
// [RULE_02] write sends command byte then data byte
// [RULE_03] read sends command, captures eight returned bits
// [RULE_04] direction bit first, bytes least significant first
// [RULE_05] command bit 0: zero write, one read
// [RULE_06] command bits 7..1 hold remote address
// [RULE_07] done flag held low while busy
// [RULE_08] completion sets done, interrupt if enabled
// [RULE_09] reading status clears the done flag
// [RULE_10] clearing done withdraws the interrupt request
// [RULE_11] setup bit 7 picks which select drives
// [RULE_12] setup bit 6 picks slow or fast clock
// [RULE_13] setup bit 0 enables completion interrupt
// [RULE_14] software writes zero to reserved bits
// [RULE_15] select low whole frame, clock only then
`timescale 1ns/1ps
`default_nettype none

module liu_serial_host_port
  import liu_serial_pkg::*;
(
  input  wire logic       mclk_in,          // processor side clock
  input  wire logic       nrst_in,          // async reset, active low
  input  wire logic [8:0] reg_addr_in,      // register address
  input  wire logic [7:0] reg_wdata_in,     // write data
  input  wire logic       reg_wr_in,        // write strobe, one cycle
  input  wire logic       reg_rd_in,        // read strobe, one cycle
  output logic      [7:0] reg_rdata_out,    // read data, registered
  output logic            shared_irq_n_out, // interrupt request, low
  input  wire logic       lclk_in,          // link clock
  output logic            shift_rate_bit_out,      // serial clock to the unit
  input  wire logic       ser_dio_in,       // serial data pin level
  output logic            ser_dio_out,      // serial data driven value
  output logic            ser_dio_oe_out,   // high while driving data
  output logic            select_out_a_n_out, // first select, low
  output logic            select_out_b_n_out  // second select, low
);

  `include "liu_serial_consts.svh"

  // bus address names the register
  function automatic logic reg_hit(input logic [8:0] addr,
                                   input logic [8:0] off);
    reg_hit = (addr == off);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // processor side declarations
  cmd_byte_t  serial_command_ff;    // last command byte accepted while not busy
  logic [7:0] serial_data_ff;       // data byte, write or returned
  logic       xfer_complete_flag_ff; // done status
  logic       select_choice_bit_ff; // setup bit 7
  logic       shift_rate_bit_ff;    // setup bit 6
  logic       complete_irq_enable_ff; // setup bit 0
  logic       busy_ff;              // transaction in flight
  link_req_t  req_ff;               // snapshot handed to the link
  logic       start_tgl_ff;         // launch event toward the link
  logic       done_pulse;           // completion seen on this side
  logic       launch;               // accepted command write
  logic       stat_read;            // status register read

  // link side declarations
  logic [1:0]  lrst_ff;      // link reset release synchroniser
  logic        lrst_n;       // link domain reset
  logic        start_pulse;  // launch seen on the link side
  logic        tick;         // half period tick
  link_state_t lstate_ff;    // link sequencer state
  logic [15:0] shreg_ff;     // outgoing bits, shifted right
  logic [4:0]  bit_ff;       // bit index within the frame
  logic        rd_frame_ff;  // current frame is a read
  logic        fast_ff;      // rate of the current frame
  logic [7:0]  rx_byte_ff;   // bits returned by the unit
  logic        done_tgl_ff;  // completion event toward processor
  logic [1:0]  dio_sync_ff;  // data pin synchroniser
  logic        dio_s;        // synchronised data pin

  ////////////////////////////////////////////////////////////////////////
  // bus decode
  assign launch    = reg_wr_in && reg_hit(reg_addr_in, `CMD_OFF)
                     && !busy_ff; // [RULE_01]
  assign stat_read = reg_rd_in && reg_hit(reg_addr_in, `STAT_OFF);

  ////////////////////////////////////////////////////////////////////////
  // command byte: address above direction bit
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      serial_command_ff <= cmd_byte_t'(`BYTE_RST);
    end else if (launch) begin
      serial_command_ff <= cmd_byte_t'(reg_wdata_in); // [RULE_05] [RULE_06]
    end
  end

  // data byte: processor write or returned byte
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      serial_data_ff <= `BYTE_RST;
    end else if (done_pulse && req_ff.cmd.op_direction_bit) begin
      serial_data_ff <= rx_byte_ff; // [RULE_03]
    end else if (reg_wr_in && reg_hit(reg_addr_in, `DATA_OFF)) begin
      serial_data_ff <= reg_wdata_in;
    end
  end

  // setup byte: defined bits only
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      select_choice_bit_ff   <= 1'b0;
      shift_rate_bit_ff      <= 1'b0;
      complete_irq_enable_ff <= 1'b0;
    end else if (reg_wr_in && reg_hit(reg_addr_in, `SETUP_OFF)) begin
      select_choice_bit_ff   <= reg_wdata_in[`SEL_BIT];   // [RULE_11]
      shift_rate_bit_ff      <= reg_wdata_in[`RATE_BIT];  // [RULE_12]
      complete_irq_enable_ff <= reg_wdata_in[`IRQEN_BIT]; // [RULE_13]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // busy flag and snapshot for the link
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      busy_ff      <= 1'b0;
      req_ff       <= '0;
      start_tgl_ff <= 1'b0;
    end else if (launch) begin
      busy_ff                  <= 1'b1;
      req_ff.select_choice_bit <= select_choice_bit_ff;
      req_ff.shift_rate_bit    <= shift_rate_bit_ff;
      req_ff.cmd               <= cmd_byte_t'(reg_wdata_in);
      req_ff.data              <= serial_data_ff; // [RULE_02]
      start_tgl_ff             <= ~start_tgl_ff;  // [RULE_01]
    end else if (done_pulse) begin
      busy_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // done flag: completion wins over a clearing read
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      xfer_complete_flag_ff <= 1'b0;
    end else if (done_pulse) begin
      xfer_complete_flag_ff <= 1'b1; // [RULE_08]
    end else if (launch) begin
      xfer_complete_flag_ff <= 1'b0; // [RULE_07]
    end else if (stat_read) begin
      xfer_complete_flag_ff <= 1'b0; // [RULE_09]
    end
  end

  // interrupt request follows the gated flag
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      shared_irq_n_out <= 1'b1;
    end else begin
      shared_irq_n_out <= !(xfer_complete_flag_ff
                            && complete_irq_enable_ff); // [RULE_10] [RULE_13]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data, reserved bits and unmapped addresses read zero
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      reg_rdata_out <= `BYTE_RST;
    end else if (reg_rd_in) begin
      reg_rdata_out <= `BYTE_RST;
      if (reg_hit(reg_addr_in, `CMD_OFF)) begin
        reg_rdata_out <= serial_command_ff;
      end
      if (reg_hit(reg_addr_in, `DATA_OFF)) begin
        reg_rdata_out <= serial_data_ff;
      end
      if (reg_hit(reg_addr_in, `STAT_OFF)) begin
        reg_rdata_out[`DONE_BIT] <= xfer_complete_flag_ff;
      end
      if (reg_hit(reg_addr_in, `SETUP_OFF)) begin
        reg_rdata_out[`SEL_BIT]   <= select_choice_bit_ff;
        reg_rdata_out[`RATE_BIT]  <= shift_rate_bit_ff;
        reg_rdata_out[`IRQEN_BIT] <= complete_irq_enable_ff;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // completion into the processor domain
  toggle_sync u_done_sync (
    .clk_in    (mclk_in),
    .nrst_in   (nrst_in),
    .tgl_in    (done_tgl_ff),
    .pulse_out (done_pulse)
  );

  ////////////////////////////////////////////////////////////////////////
  // link reset: asserted at once, released on the link clock
  always_ff @(posedge lclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      lrst_ff <= 2'h0;
    end else begin
      lrst_ff <= {lrst_ff[0], 1'b1};
    end
  end

  assign lrst_n = lrst_ff[1];

  // launch crossing into the link domain
  toggle_sync u_start_sync (
    .clk_in    (lclk_in),
    .nrst_in   (lrst_n),
    .tgl_in    (start_tgl_ff),
    .pulse_out (start_pulse)
  );

  // data pin synchroniser, first stage read only by the second
  always_ff @(posedge lclk_in or negedge lrst_n) begin
    if (!lrst_n) begin
      dio_sync_ff <= 2'h0;
    end else begin
      dio_sync_ff <= {dio_sync_ff[0], ser_dio_in};
    end
  end

  assign dio_s = dio_sync_ff[1];

  // half period ticks while a frame runs
  shift_tick_gen u_tick (
    .lclk_in  (lclk_in),
    .nrst_in  (lrst_n),
    .run_in   (lstate_ff != L_IDLE),
    .fast_in  (fast_ff),
    .tick_out (tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // link sequencer: lead, 16 clock periods, tail
  always_ff @(posedge lclk_in or negedge lrst_n) begin
    if (!lrst_n) begin
      lstate_ff <= L_IDLE;
    end else begin
      case (lstate_ff)
        L_IDLE: begin
          if (start_pulse) begin
            lstate_ff <= L_LEAD;
          end
        end
        L_LEAD: begin
          if (tick) begin
            lstate_ff <= L_LOW;
          end
        end
        L_LOW: begin
          if (tick) begin
            lstate_ff <= L_HIGH;
          end
        end
        L_HIGH: begin
          if (tick) begin
            lstate_ff <= (bit_ff == `LAST_BIT) ? L_TAIL : L_LOW;
          end
        end
        L_TAIL: begin
          if (tick) begin
            lstate_ff <= L_IDLE;
          end
        end
        default: begin
          lstate_ff <= L_IDLE;
        end
      endcase
    end
  end

  // frame setup, shifter and bit index
  always_ff @(posedge lclk_in or negedge lrst_n) begin
    if (!lrst_n) begin
      shreg_ff    <= 16'h0000;
      bit_ff      <= 5'h00;
      rd_frame_ff <= 1'b0;
      fast_ff     <= 1'b0;
    end else if (lstate_ff == L_IDLE && start_pulse) begin
      shreg_ff    <= {req_ff.data, req_ff.cmd}; // [RULE_02] [RULE_04]
      bit_ff      <= 5'h00;
      rd_frame_ff <= req_ff.cmd.op_direction_bit; // [RULE_05]
      fast_ff     <= req_ff.shift_rate_bit;       // [RULE_12]
    end else if (lstate_ff == L_HIGH && tick) begin
      shreg_ff <= {1'b0, shreg_ff[15:1]}; // [RULE_04]
      bit_ff   <= bit_ff + 5'h01;
    end
  end

  // serial clock toggles only inside the select window
  always_ff @(posedge lclk_in or negedge lrst_n) begin
    if (!lrst_n) begin
      shift_rate_bit_out <= 1'b0;
    end else if (tick && lstate_ff == L_LOW) begin
      shift_rate_bit_out <= 1'b1; // [RULE_15]
    end else if (tick && lstate_ff == L_HIGH) begin
      shift_rate_bit_out <= 1'b0;
    end
  end

  // data pin: drive outgoing bits, release for the returned byte
  always_ff @(posedge lclk_in or negedge lrst_n) begin
    if (!lrst_n) begin
      ser_dio_out    <= 1'b0;
      ser_dio_oe_out <= 1'b0;
    end else if (lstate_ff == L_IDLE && start_pulse) begin
      ser_dio_out    <= req_ff.cmd.op_direction_bit; // [RULE_04]
      ser_dio_oe_out <= 1'b1;
    end else if (lstate_ff == L_HIGH && tick) begin
      ser_dio_out <= shreg_ff[1];
      if (bit_ff == `LAST_BIT) begin
        ser_dio_oe_out <= 1'b0;
      end else if (rd_frame_ff && bit_ff == `BYTE_BITS - 5'h01) begin
        ser_dio_oe_out <= 1'b0; // [RULE_03]
      end
    end
  end

  // returned byte, first bit lands in bit 0
  always_ff @(posedge lclk_in or negedge lrst_n) begin
    if (!lrst_n) begin
      rx_byte_ff <= `BYTE_RST;
    end else if (lstate_ff == L_LOW && tick && rd_frame_ff
                 && bit_ff >= `BYTE_BITS) begin
      rx_byte_ff <= {dio_s, rx_byte_ff[7:1]}; // [RULE_03] [RULE_04]
    end
  end

  // chip selects: one low for the whole frame
  always_ff @(posedge lclk_in or negedge lrst_n) begin
    if (!lrst_n) begin
      select_out_a_n_out <= 1'b1;
      select_out_b_n_out <= 1'b1;
    end else if (lstate_ff == L_IDLE && start_pulse) begin
      select_out_a_n_out <= req_ff.select_choice_bit;  // [RULE_11]
      select_out_b_n_out <= !req_ff.select_choice_bit; // [RULE_11]
    end else if (lstate_ff == L_TAIL && tick) begin
      select_out_a_n_out <= 1'b1; // [RULE_15]
      select_out_b_n_out <= 1'b1;
    end
  end

  // completion event back
  always_ff @(posedge lclk_in or negedge lrst_n) begin
    if (!lrst_n) begin
      done_tgl_ff <= 1'b0;
    end else if (lstate_ff == L_TAIL && tick) begin
      done_tgl_ff <= ~done_tgl_ff; // [RULE_08]
    end
  end

endmodule

`default_nettype wire

// [verif/liu_serial_host_port_chk.sv]
// assertion checker for the serial host port
`timescale 1ns/1ps
`default_nettype none
`include "liu_serial_consts.svh"
module liu_serial_host_port_chk
  import liu_serial_pkg::*;
(
  input wire logic       mclk_in,            // clk
  input wire logic       nrst_in,            // reset
  input wire logic [8:0] reg_addr_in,        // addr
  input wire logic [7:0] reg_wdata_in,       // wdata
  input wire logic       reg_wr_in,          // write
  input wire logic       reg_rd_in,          // read
  input wire logic [7:0] reg_rdata_out,      // rdata
  input wire logic       shared_irq_n_out,   // irq
  input wire logic       lclk_in,            // link clk
  input wire logic       shift_rate_bit_out,        // serial clk
  input wire logic       ser_dio_out,        // data
  input wire logic       ser_dio_oe_out,     // data enable
  input wire logic       select_out_a_n_out, // select a
  input wire logic       select_out_b_n_out  // select b
);
  logic [7:0] cmd_ff;   // accepted command
  logic [7:0] setup_ff; // setup shadow
  logic [4:0] rise_ff;  // clock rises in frame
  logic       clk_q_ff; // clock last cycle
  wire        sel_idle = select_out_a_n_out & select_out_b_n_out;
  wire        stat_rd  = reg_rd_in && reg_addr_in == `STAT_OFF;
  ////////////////////////////////////////////////////////////////
  // shadows of writes made while idle
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cmd_ff   <= `BYTE_RST;
      setup_ff <= `BYTE_RST;
    end else if (reg_wr_in && sel_idle) begin
      if (reg_addr_in == `CMD_OFF) cmd_ff <= reg_wdata_in;
      if (reg_addr_in == `SETUP_OFF) setup_ff <= reg_wdata_in;
    end
  end
  // serial clock rises in a frame
  always_ff @(posedge lclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rise_ff  <= 5'h00;
      clk_q_ff <= 1'b0;
    end else begin
      clk_q_ff <= shift_rate_bit_out;
      if (sel_idle) rise_ff <= 5'h00;
      else if (shift_rate_bit_out && !clk_q_ff) rise_ff <= rise_ff + 5'h01;
    end
  end
  ////////////////////////////////////////////////////////////////
  property p_busy_done;
    @(posedge mclk_in) disable iff (!nrst_in) stat_rd && !sel_idle |=> !reg_rdata_out[0];
  endproperty
  a_busy_done: assert property (p_busy_done) else $error("done while busy");
  property p_rd_clear;
    @(posedge mclk_in) disable iff (!nrst_in)
      stat_rd && !shared_irq_n_out |=> reg_rdata_out[0] ##[1:2] shared_irq_n_out;
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("irq not withdrawn");
  property p_irq_gate;
    @(posedge mclk_in) disable iff (!nrst_in)
      $fell(shared_irq_n_out) |-> setup_ff[`IRQEN_BIT] && sel_idle;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq not gated");
  property p_sel_pick;
    @(posedge mclk_in) disable iff (!nrst_in) !sel_idle |->
      select_out_a_n_out == setup_ff[`SEL_BIT] && select_out_b_n_out == !setup_ff[`SEL_BIT];
  endproperty
  a_sel_pick: assert property (p_sel_pick) else $error("wrong select");
  property p_clk_frame;
    @(posedge lclk_in) disable iff (!nrst_in) shift_rate_bit_out || ser_dio_oe_out |-> !sel_idle;
  endproperty
  a_clk_frame: assert property (p_clk_frame) else $error("clock outside frame");
  property p_first_bit;
    @(posedge lclk_in) disable iff (!nrst_in)
      $fell(sel_idle) |-> ser_dio_oe_out && ser_dio_out == cmd_ff[`DIR_BIT];
  endproperty
  a_first_bit: assert property (p_first_bit) else $error("first bit wrong");
  property p_fast;
    @(posedge lclk_in) disable iff (!nrst_in)
      $rose(shift_rate_bit_out) && setup_ff[`RATE_BIT] |=> !shift_rate_bit_out;
  endproperty
  a_fast: assert property (p_fast) else $error("fast high time");
  property p_slow;
    @(posedge lclk_in) disable iff (!nrst_in)
      $rose(shift_rate_bit_out) && !setup_ff[`RATE_BIT] |-> shift_rate_bit_out [*8] ##1 !shift_rate_bit_out;
  endproperty
  a_slow: assert property (p_slow) else $error("slow high time");
  property p_rd_release;
    @(posedge lclk_in) disable iff (!nrst_in)
      shift_rate_bit_out && rise_ff > 5'h08 && cmd_ff[`DIR_BIT] |-> !ser_dio_oe_out;
  endproperty
  a_rd_release: assert property (p_rd_release) else $error("pin kept on read");
  c_read: cover property (@(posedge lclk_in) shift_rate_bit_out && rise_ff > 5'h08 && cmd_ff[0]);
  c_fast: cover property (@(posedge lclk_in) $rose(shift_rate_bit_out) && setup_ff[6]);
  c_irq: cover property (@(posedge mclk_in) $fell(shared_irq_n_out));
endmodule
bind liu_serial_host_port liu_serial_host_port_chk u_chk (.mclk_in, .nrst_in, .reg_addr_in,
  .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .shared_irq_n_out, .lclk_in,
  .shift_rate_bit_out, .ser_dio_out, .ser_dio_oe_out, .select_out_a_n_out, .select_out_b_n_out);
`default_nettype wire

// [verif/line_unit_model.sv]
// behavioural model of the far line unit
`timescale 1ns/1ps
`default_nettype none
module line_unit_model (
  input  wire logic shift_rate_bit_in, // serial clock
  input  wire logic sel_a_n_in, // select a
  input  wire logic sel_b_n_in, // select b
  input  wire logic dio_in,     // port value
  input  wire logic dio_oe_in,  // port enable
  output logic      line_out    // resolved line
);
  logic [7:0]  mem [0:127]; // unit registers
  logic [15:0] sh_ff;       // frame bits
  logic [4:0]  nbits;       // bits seen
  logic        drv_en;      // unit drives
  logic        drv_bit;     // unit bit
  logic        idle_bit;    // released level
  logic [7:0]  last_cmd;    // last command
  logic [7:0]  last_data;   // last data
  int          last_bits;   // last bit count
  int          period_ns;   // last clock period
  realtime     t_rise;      // last rise
  wire         frame_on = !(sel_a_n_in && sel_b_n_in);
  initial begin
    for (int i = 0; i < 128; i++) mem[i] = 8'hC3 ^ 8'(i);
    drv_en = 1'b0;
    idle_bit = 1'b1;
  end
  // released line shows inverse of last level
  assign line_out = dio_oe_in ? dio_in : (drv_en ? drv_bit : idle_bit);
  always @(negedge dio_oe_in) idle_bit = ~dio_in;
  always @(posedge frame_on) nbits = 5'h00;
  // take a bit at each rise, first bit first
  always @(posedge shift_rate_bit_in) if (frame_on) begin
    if (nbits < 5'h10) sh_ff[nbits] = line_out;
    period_ns = int'($realtime - t_rise);
    t_rise = $realtime;
    nbits++;
  end
  // read answer lsb first, changed at the fall
  always @(negedge shift_rate_bit_in) if (frame_on && sh_ff[0] && nbits[4:3] == 2'h1) begin
    drv_en = 1'b1;
    drv_bit = mem[sh_ff[7:1]][nbits-5'h08];
  end
  always @(negedge frame_on) begin
    if (!sh_ff[0]) mem[sh_ff[7:1]] = sh_ff[15:8];
    last_cmd = sh_ff[7:0];
    last_data = sh_ff[15:8];
    last_bits = nbits;
    if (drv_en) idle_bit = ~drv_bit;
    drv_en = 1'b0;
  end
endmodule
`default_nettype wire

// [verif/liu_serial_host_port_bench.sv]
// self-checking bench for the serial host port
`timescale 1ns/1ps
`default_nettype none
`include "liu_serial_consts.svh"
module liu_serial_host_port_bench;
  typedef struct packed {
    logic b, fast, en, dir;
    logic [6:0] addr;
    logic [7:0] data;
  } tcase_t;
  logic       mclk_in = 1'b0;      // processor clock
  logic       lclk_in = 1'b0;      // link clock
  logic       nrst_in = 1'b0;      // reset
  logic [8:0] reg_addr_in = 9'h000;
  logic [7:0] reg_wdata_in = 8'h00;
  logic       reg_wr_in = 1'b0;
  logic       reg_rd_in = 1'b0;
  logic [7:0] reg_rdata_out, rd_val, memx [0:127];
  logic       shared_irq_n_out, shift_rate_bit_out, ser_dio_in, ser_dio_out, ser_dio_oe_out;
  logic       select_out_a_n_out, select_out_b_n_out;
  int         num_errors = 0, checks = 0, cycles = 0;
  tcase_t     tcs [0:3];
  tcase_t     tc;
  ////////////////////////////////////////////////////////////////
  always #12.5 mclk_in = ~mclk_in;
  initial begin
    #3;
    forever #40 lclk_in = ~lclk_in;
  end
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      complete_run();
    end
  end
  liu_serial_host_port u_liu_serial_host_port (.mclk_in, .nrst_in, .reg_addr_in, .reg_wdata_in,
    .reg_wr_in, .reg_rd_in, .reg_rdata_out, .shared_irq_n_out, .lclk_in, .shift_rate_bit_out,
    .ser_dio_in, .ser_dio_out, .ser_dio_oe_out, .select_out_a_n_out, .select_out_b_n_out);
  line_unit_model u_line_unit_model (.shift_rate_bit_in(shift_rate_bit_out), .sel_a_n_in(select_out_a_n_out),
    .sel_b_n_in(select_out_b_n_out), .dio_in(ser_dio_out), .dio_oe_in(ser_dio_oe_out),
    .line_out(ser_dio_in));
  ////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(negedge mclk_in);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1'b1;
    @(negedge mclk_in);
    reg_wr_in = 1'b0;
  endtask
  // data is registered at the strobe edge
  task automatic rd(input logic [8:0] a, output logic [7:0] d);
    @(negedge mclk_in);
    reg_addr_in = a;
    reg_rd_in = 1'b1;
    @(negedge mclk_in);
    reg_rd_in = 1'b0;
    d = reg_rdata_out;
  endtask
  // lvl 0: a select low, 1: both high
  task automatic wait_sel(input logic lvl);
    int n = 0;
    while ((select_out_a_n_out & select_out_b_n_out) !== lvl && n < 4000) begin
      @(negedge mclk_in);
      n++;
    end
    if (n == 4000) num_errors++;
  endtask
  task automatic complete_run();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    for (int i = 0; i < 128; i++) memx[i] = 8'hC3 ^ 8'(i);
    tcs[0] = {4'b0010, 7'h55, 8'hA3};
    tcs[1] = {4'b1100, 7'h2A, 8'h5C};
    tcs[2] = {4'b0011, 7'h55, 8'h00};
    tcs[3] = {4'b1001, 7'h13, 8'h00};
    repeat (20) @(negedge mclk_in);
    nrst_in = 1'b1;
    repeat (20) @(negedge mclk_in);
    rd(`STAT_OFF, rd_val);
    check("status reset", rd_val, 8'h00);
    wr(9'h026, 8'hFF);
    rd(9'h026, rd_val);
    check("unmapped", rd_val, 8'h00);
    check("idle pins", {select_out_a_n_out, select_out_b_n_out, shift_rate_bit_out}, 3'b110);
    for (int i = 0; i < 4; i++) begin
      tc = tcs[i];
      wr(`SETUP_OFF, {tc.b, tc.fast, 5'h00, tc.en});
      rd(`SETUP_OFF, rd_val);
      check("setup", rd_val, {tc.b, tc.fast, 5'h00, tc.en});
      wr(`DATA_OFF, tc.data);
      wr(`CMD_OFF, {tc.addr, tc.dir});
      wait_sel(1'b0);
      check("select a", select_out_a_n_out, tc.b);
      check("select b", select_out_b_n_out, !tc.b);
      wr(`CMD_OFF, 8'hFE);
      rd(`STAT_OFF, rd_val);
      check("busy done", rd_val, 8'h00);
      wait_sel(1'b1);
      repeat (8) @(negedge mclk_in);
      check("irq", shared_irq_n_out, !tc.en);
      rd(`STAT_OFF, rd_val);
      check("done", rd_val, 8'h01);
      repeat (2) @(negedge mclk_in);
      check("irq off", shared_irq_n_out, 1'b1);
      rd(`STAT_OFF, rd_val);
      check("done off", rd_val, 8'h00);
      check("cmd sent", u_line_unit_model.last_cmd, {tc.addr, tc.dir});
      check("bit count", u_line_unit_model.last_bits, 16);
      check("period", u_line_unit_model.period_ns, tc.fast ? 160 : 1280);
      if (tc.dir) begin
        rd(`DATA_OFF, rd_val);
        check("read data", rd_val, memx[tc.addr]);
      end else begin
        check("data sent", u_line_unit_model.last_data, tc.data);
        memx[tc.addr] = tc.data;
      end
    end
    complete_run();
  end
endmodule
`default_nettype wire
